// ==== rtl/cpu_arith_bit_branch_exec.sv ====
// What this block does
// - add accumulator to file register, update flags
// - destination bit picks accumulator or file
// - shift bits right, bit zero into carry
// - shift keeps top bit, touches carry, zero only
// - add with carry sums accumulator, file, carry
// - bit clear zeroes one bit, no flags
// - clear bit found means next slot discarded
// - set bit found means next runs normally
// - branch loads incremented pc plus signed offset
// - branch flushes fetched instruction, two cycles
`timescale 1ns/1ps
module cpu_arith_bit_branch_exec (
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  output logic          [exec_pkg::PC_W-1:0]      prog_addr,
  input  wire exec_pkg::inst_type                 prog_rdata,
  output exec_pkg::file_req_type                  file_req,
  input  wire logic     [exec_pkg::DATA_W-1:0]    file_rdata,
  output logic          [exec_pkg::DATA_W-1:0]    acc,
  output exec_pkg::status_type                    status,
  output exec_pkg::phase_type                     phase,
  output logic                                    slot_discarded
);
  import exec_pkg::*;

  typedef struct packed {
    phase_type          phase;
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    prog_addr;
    inst_type           exec;
    logic               discarded;
    logic               flush;
    logic [DATA_W-1:0]  operand;
    logic [DATA_W-1:0]  acc;
    status_type         status;
    file_req_type       file;
  } core_state_type;

  localparam core_state_type STATE_RESET = '{
    phase:     phase_q1,
    pc:        PC_RESET,
    prog_addr: PC_RESET,
    exec:      NOP_INST,
    discarded: 1'b1,
    flush:     1'b0,
    operand:   ZERO_VALUE,
    acc:       ACC_RESET,
    status:    STATUS_RESET,
    file:      FILE_REQ_RESET
  };

  core_state_type st;
  core_state_type next_st;

  logic [NIB_W-1:0]  sum_lo;
  logic [NIB_W-1:0]  sum_hi;
  logic              nibble_carry;
  logic              byte_carry;
  logic              add_carry_in;
  logic [DATA_W-1:0] bit_cleared;
  logic              bit_picked;
  logic [PC_W-1:0]   branch_step;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and bit helpers

  assign add_carry_in = (st.exec.op == op_add_acc_file_with_carry) ? st.status.carry : 1'b0;

  // the offset is two's complement, so it widens with copies of its sign bit
  assign branch_step = {{(PC_W-OFF_W){st.exec.offset[OFF_W-1]}}, st.exec.offset};

  carry_add_slice #(.W(NIB_W)) add_lo (
    .a         (st.acc[NIB_W-1:0]),
    .b         (st.operand[NIB_W-1:0]),
    .carry_in  (add_carry_in),
    .sum       (sum_lo),
    .carry_out (nibble_carry)
  );

  carry_add_slice #(.W(NIB_W)) add_hi (
    .a         (st.acc[DATA_W-1:NIB_W]),
    .b         (st.operand[DATA_W-1:NIB_W]),
    .carry_in  (nibble_carry),
    .sum       (sum_hi),
    .carry_out (byte_carry)
  );

  bit_select_unit #(.W(DATA_W), .SW(BIT_W)) bit_unit (
    .value   (st.operand),
    .sel     (st.exec.bit_sel),
    .cleared (bit_cleared),
    .picked  (bit_picked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle: q1 address, q2 read, q3 execute, q4 write and fetch

  always_comb begin
    logic [DATA_W-1:0] result;
    logic              write_result;
    result       = ZERO_VALUE;
    write_result = 1'b0;
    next_st      = st;
    case (st.phase)
      phase_q1: begin
        next_st.phase     = phase_q2;
        next_st.prog_addr = st.pc;
        next_st.file.addr = st.exec.file;
      end
      phase_q2: begin
        next_st.phase   = phase_q3;
        next_st.operand = file_rdata;
      end
      phase_q3: begin
        next_st.phase = phase_q4;
        // pc already points past this instruction, so branch is relative to it
        next_st.pc    = st.pc + PC_STEP;
        case (st.exec.op)
          op_add_acc_to_file, op_add_acc_file_with_carry: begin
            result       = {sum_hi, sum_lo};
            write_result = 1'b1;
            next_st.status.carry            = byte_carry;
            next_st.status.digit_carry_flag = nibble_carry;
            next_st.status.zero             = (result == ZERO_VALUE);
          end
          op_arith_shift_right_file: begin
            result       = {st.operand[DATA_W-1], st.operand[DATA_W-1:1]};
            write_result = 1'b1;
            next_st.status.carry = st.operand[0];
            next_st.status.zero  = (result == ZERO_VALUE);
          end
          op_bit_clear_file: begin
            // always written back; the destination bit is not part of this one
            next_st.file.wdata = bit_cleared;
            next_st.file.we    = 1'b1;
          end
          op_bit_test_skip_when_clear: begin
            next_st.flush = ~bit_picked;
          end
          op_relative_branch: begin
            next_st.pc    = st.pc + branch_step;
            next_st.flush = 1'b1;
          end
          default: begin
          end
        endcase
        if (write_result) begin
          if (st.exec.dest == DEST_FILE) begin
            next_st.file.wdata = result;
            next_st.file.we    = 1'b1;
          end else begin
            next_st.acc = result;
          end
        end
      end
      phase_q4: begin
        next_st.phase     = phase_q1;
        next_st.file.we   = 1'b0;
        // a flushed slot still takes its full cycle but does nothing
        next_st.discarded = st.flush;
        next_st.exec      = st.flush ? NOP_INST : prog_rdata;
        next_st.flush     = 1'b0;
      end
      default: begin
        next_st.phase = phase_q1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prog_addr      = st.prog_addr;
  assign file_req       = st.file;
  assign acc            = st.acc;
  assign status         = st.status;
  assign phase          = st.phase;
  assign slot_discarded = st.discarded;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic q4_now;
  logic q3_now;
  assign q4_now = (st.phase == phase_q4);
  assign q3_now = (st.phase == phase_q3);

  AST_ADD_TO_ACC: assert property (
    q4_now && st.exec.op == op_add_acc_to_file && st.exec.dest == DEST_ACC
    |-> {st.status.carry, st.acc} == 9'($past(st.acc)) + 9'(st.operand))
    else $error("add to accumulator gave wrong sum or carry");

  AST_DEST_FILE: assert property (
    q4_now && st.exec.dest == DEST_FILE
    && st.exec.op inside {op_add_acc_to_file, op_add_acc_file_with_carry,
                          op_arith_shift_right_file}
    |-> st.file.we && st.file.addr == st.exec.file && st.acc == $past(st.acc))
    else $error("file destination not written or accumulator disturbed");

  AST_SHIFT_BITS: assert property (
    q4_now && st.exec.op == op_arith_shift_right_file
    |-> (st.exec.dest ? st.file.wdata : st.acc) == {st.operand[7], st.operand[7:1]}
        && st.status.carry == st.operand[0])
    else $error("arithmetic shift result or carry wrong");

  AST_SHIFT_FLAGS: assert property (
    q4_now && st.exec.op == op_arith_shift_right_file
    |-> st.status.digit_carry_flag == $past(st.status.digit_carry_flag))
    else $error("arithmetic shift changed digit carry");

  AST_ADD_CARRY: assert property (
    q4_now && st.exec.op == op_add_acc_file_with_carry && st.exec.dest == DEST_ACC
    |-> {st.status.carry, st.acc}
        == 9'($past(st.acc)) + 9'(st.operand) + 9'($past(st.status.carry)))
    else $error("add with carry gave wrong sum");

  AST_BIT_CLEAR: assert property (
    q4_now && st.exec.op == op_bit_clear_file
    |-> st.file.we && st.file.wdata == (st.operand & ~(8'h01 << st.exec.bit_sel))
        && st.status == $past(st.status) && st.acc == $past(st.acc))
    else $error("bit clear wrote wrong value or changed flags");

  AST_SKIP_TAKEN: assert property (
    q3_now && st.exec.op == op_bit_test_skip_when_clear
    && !st.operand[st.exec.bit_sel]
    |=> st.flush ##1 (st.discarded && st.exec.op == op_nop) ##3 q4_now)
    else $error("clear bit did not discard the next instruction");

  AST_SKIP_NOT_TAKEN: assert property (
    q3_now && st.exec.op == op_bit_test_skip_when_clear
    && st.operand[st.exec.bit_sel]
    |=> !st.flush && st.status == $past(st.status) ##1 !st.discarded)
    else $error("set bit still skipped or changed flags");

  AST_BRANCH_TARGET: assert property (
    q3_now && st.exec.op == op_relative_branch
    |=> st.pc == $past(st.pc) + {{6{$past(st.exec.offset[8])}}, $past(st.exec.offset)}
        && st.status == $past(st.status))
    else $error("branch target wrong or flags changed");

  AST_BRANCH_FLUSH: assert property (
    q3_now && st.exec.op == op_relative_branch
    |=> st.flush ##1 (st.discarded && st.exec.op == op_nop) ##1 !st.file.we [*3])
    else $error("branch did not flush the fetched instruction");

  AST_ZERO_FLAG: assert property (
    q4_now && st.exec.op inside {op_add_acc_to_file, op_add_acc_file_with_carry,
                                 op_arith_shift_right_file}
    |-> st.status.zero == ((st.exec.dest ? st.file.wdata : st.acc) == 8'h00))
    else $error("zero flag does not match result");

  AST_DIGIT_CARRY: assert property (
    q4_now && st.exec.op == op_add_acc_to_file
    |-> st.status.digit_carry_flag
        == ((5'($past(st.acc[3:0])) + 5'(st.operand[3:0])) > 5'h0f))
    else $error("digit carry wrong after add");

  AST_WRITE_PULSE: assert property (
    st.file.we |-> q4_now ##1 !st.file.we)
    else $error("file write strobe longer than one clock");

  AST_ADD_TO_FILE: assert property (
    q4_now && st.exec.op == op_add_acc_to_file && st.exec.dest == DEST_FILE
    |-> {st.status.carry, st.file.wdata} == 9'(st.acc) + 9'(st.operand))
    else $error("add to file wrote wrong sum or carry");

  AST_NOP_QUIET: assert property (
    q4_now && st.discarded
    |-> !st.file.we && st.acc == $past(st.acc) && st.status == $past(st.status))
    else $error("discarded slot changed accumulator, flags or file");

  AST_PC_STEP: assert property (
    q3_now && st.exec.op != op_relative_branch
    |=> st.pc == $past(st.pc) + PC_STEP)
    else $error("program counter did not advance by one");

  AST_FETCH_ADDR: assert property (
    st.phase == phase_q2 |-> st.prog_addr == st.pc)
    else $error("fetch address does not follow the program counter");

  AST_FLUSH_SHORT: assert property (
    st.flush |-> q4_now)
    else $error("flush request outlived its phase");

  COV_ADD_TO_FILE: cover property (
    q4_now && st.exec.op == op_add_acc_to_file && st.exec.dest == DEST_FILE);

  COV_SKIP_TAKEN: cover property (
    q3_now && st.exec.op == op_bit_test_skip_when_clear && !bit_picked);

  COV_BRANCH_BACK: cover property (
    q3_now && st.exec.op == op_relative_branch && st.exec.offset[8]);

  COV_CARRY_CHAIN: cover property (
    q4_now && st.exec.op == op_add_acc_file_with_carry && $past(st.status.carry));

  COV_SKIP_KEPT: cover property (
    q3_now && st.exec.op == op_bit_test_skip_when_clear && bit_picked);

endmodule

// ==== rtl/exec_pkg.sv ====
package exec_pkg;

  localparam int PC_W    = 15;
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 7;
  localparam int BIT_W   = 3;
  localparam int OFF_W   = 9;
  localparam int NIB_W   = 4;

  localparam logic [PC_W-1:0]   PC_RESET   = 15'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 15'h0001;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_VALUE = 8'h00;

  // polarity of the destination select and its two meanings
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // operation codes of the decoded instruction word; nop is all zeros
  typedef enum logic [2:0] {
    op_nop                      = 3'h0,
    op_add_acc_to_file          = 3'h1,
    op_add_acc_file_with_carry  = 3'h2,
    op_arith_shift_right_file   = 3'h3,
    op_bit_clear_file           = 3'h4,
    op_bit_test_skip_when_clear = 3'h5,
    op_relative_branch          = 3'h6
  } op_type;

  // four clock phases form one instruction cycle, gray ordered
  typedef enum logic [1:0] {
    phase_q1 = 2'h0,
    phase_q2 = 2'h1,
    phase_q3 = 2'h3,
    phase_q4 = 2'h2
  } phase_type;

  typedef struct packed {
    op_type             op;
    logic               dest;
    logic [BIT_W-1:0]   bit_sel;
    logic [FILE_AW-1:0] file;
    logic [OFF_W-1:0]   offset;
  } inst_type;

  localparam inst_type NOP_INST = '0;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } status_type;

  localparam status_type STATUS_RESET = '0;

  typedef struct packed {
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0]  wdata;
    logic               we;
  } file_req_type;

  localparam file_req_type FILE_REQ_RESET = '0;

endpackage

// ==== rtl/carry_add_slice.sv ====
`timescale 1ns/1ps
// one slice of a ripple adder; two of them give the nibble carry for free
module carry_add_slice #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         carry_in,
  output logic      [W-1:0] sum,
  output logic              carry_out
);

  logic [W:0] full;

  always_comb begin
    full      = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, carry_in};
    sum       = full[W-1:0];
    carry_out = full[W];
  end

endmodule

// ==== rtl/bit_select_unit.sv ====
`timescale 1ns/1ps
module bit_select_unit #(
  parameter int W  = 8,
  parameter int SW = 3
) (
  input  wire logic [W-1:0]  value,
  input  wire logic [SW-1:0] sel,
  output logic      [W-1:0]  cleared,
  output logic               picked
);

  always_comb begin
    cleared = value;
    cleared[sel] = 1'b0;
    picked = value[sel];
  end

endmodule

// ==== verif/mem_model.sv ====
`timescale 1ns/1ps
// data and program memory both answer combinationally from the registered addresses
module mem_model (
  input  wire logic                      ref_clk,
  input  wire logic [exec_pkg::PC_W-1:0] prog_addr,
  output exec_pkg::inst_type             prog_rdata,
  input  wire exec_pkg::file_req_type    file_req,
  output logic [exec_pkg::DATA_W-1:0]    file_rdata
);
  import exec_pkg::*;

  inst_type          prog [2**PC_W];
  logic [DATA_W-1:0] file [2**FILE_AW];

  assign prog_rdata = prog[prog_addr];
  assign file_rdata = file[file_req.addr];

  always @(posedge ref_clk) begin
    if (file_req.we) begin
      file[file_req.addr] <= file_req.wdata;
    end
  end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0]    pa;
    logic [DATA_W-1:0]  acc;
    status_type         st;
    logic               disc;
    logic               we;
    logic [FILE_AW-1:0] fa;
    logic [DATA_W-1:0]  wd;
  } exp_type;

  localparam int SLOTS = 600;
  localparam int LIMIT = 4 * SLOTS + 200;

  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [PC_W-1:0]   prog_addr;
  inst_type          prog_rdata;
  file_req_type      file_req;
  logic [DATA_W-1:0] file_rdata;
  logic [DATA_W-1:0] acc;
  status_type        status;
  phase_type         phase;
  logic              slot_discarded;
  exp_type           notes [$];
  exp_type           got;
  logic [DATA_W-1:0] fref [2**FILE_AW];
  int                n_mismatch = 0;
  int                checked = 0;
  int                cycles = 0;
  int                seed = 32'h3a12494d;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  cpu_arith_bit_branch_exec uut (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .prog_addr      (prog_addr),
    .prog_rdata     (prog_rdata),
    .file_req       (file_req),
    .file_rdata     (file_rdata),
    .acc            (acc),
    .status         (status),
    .phase          (phase),
    .slot_discarded (slot_discarded)
  );

  mem_model mem (
    .ref_clk    (ref_clk),
    .prog_addr  (prog_addr),
    .prog_rdata (prog_rdata),
    .file_req   (file_req),
    .file_rdata (file_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // random program plus a reference run of it, one note per instruction slot
  task automatic build;
    inst_type          cur;
    inst_type          ins;
    exp_type           e;
    logic [31:0]       r;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   nxt;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] f;
    logic [DATA_W-1:0] res;
    logic [8:0]        sum;
    logic [4:0]        low;
    logic              cin;
    logic              flush;
    logic              to_acc;
    logic              to_file;
    status_type        st;
    for (int i = 0; i < 2**PC_W; i++) begin
      r = $random(seed);
      mem.prog[i] = inst_type'(r[22:0]);
    end
    for (int i = 0; i < 2**FILE_AW; i++) begin
      r = $random(seed);
      fref[i] = r[7:0];
      mem.file[i] = r[7:0];
    end
    // extreme offsets, the second one wraps the pc back to address 1
    ins = NOP_INST;
    ins.op = op_relative_branch;
    ins.offset = 9'h100;
    mem.prog[0] = ins;
    ins.offset = 9'h0ff;
    mem.prog[15'h7f01] = ins;
    pc = PC_RESET;
    cur = NOP_INST;
    e.disc = 1'b1;
    a = ACC_RESET;
    st = STATUS_RESET;
    repeat (SLOTS) begin
      f = fref[cur.file];
      res = f;
      flush = 1'b0;
      to_acc = 1'b0;
      to_file = 1'b0;
      case (cur.op)
        op_add_acc_to_file, op_add_acc_file_with_carry: begin
          cin = (cur.op == op_add_acc_file_with_carry) & st.carry;
          low = {1'b0, a[3:0]} + {1'b0, f[3:0]} + {4'h0, cin};
          sum = {1'b0, a} + {1'b0, f} + {8'h00, cin};
          res = sum[7:0];
          st.digit_carry_flag = low[4];
          st.carry = sum[8];
          st.zero = (res == ZERO_VALUE);
          to_acc = (cur.dest == DEST_ACC);
          to_file = (cur.dest == DEST_FILE);
        end
        op_arith_shift_right_file: begin
          res = {f[7], f[7:1]};
          st.carry = f[0];
          st.zero = (res == ZERO_VALUE);
          to_acc = (cur.dest == DEST_ACC);
          to_file = (cur.dest == DEST_FILE);
        end
        op_bit_clear_file: begin
          res = f & ~(8'h01 << cur.bit_sel);
          to_file = 1'b1;
        end
        op_bit_test_skip_when_clear: flush = ~f[cur.bit_sel];
        op_relative_branch: flush = 1'b1;
        default: ;
      endcase
      if (to_acc) begin
        a = res;
      end
      if (to_file) begin
        fref[cur.file] = res;
      end
      e.pa = pc;
      e.acc = a;
      e.st = st;
      e.we = to_file;
      e.fa = cur.file;
      e.wd = res;
      notes.push_back(e);
      e.disc = flush;
      nxt = pc + PC_STEP;
      if (cur.op == op_relative_branch) begin
        nxt = pc + {{(PC_W - OFF_W){cur.offset[OFF_W-1]}}, cur.offset};
      end
      cur = flush ? NOP_INST : mem.prog[pc];
      pc = nxt;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // acc and status settle at the q3 edge, so the q4 phase shows one whole slot
  always @(negedge ref_clk) begin
    if (!rst && phase === phase_q4 && notes.size() > 0) begin
      got = notes.pop_front();
      check(prog_addr, got.pa, "fetch address");
      check(acc, got.acc, "accumulator");
      check(status, got.st, "status");
      check(slot_discarded, got.disc, "discard flag");
      check(file_req.we, got.we, "write strobe");
      if (got.we) begin
        check(file_req.addr, got.fa, "write address");
        check(file_req.wdata, got.wd, "write data");
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    build();
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    while (notes.size() > 0) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    complete_run();
  end
endmodule
